// ==== core/arc_flash_detection.sv ====
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
`include "arc_params.svh"

module arc_flash_detection
	import arc_pkg::*;
#(
	parameter int    CNT_W                = 16,
	parameter int    FAULT_DEPTH          = 8,
	parameter longint FORCE_TIMEOUT_CYCLES = longint'(`FORCE_TIMEOUT_S) * `CLOCK_HZ
)
(
	input  wire logic             i_clock,            // 50 MHz clock
	input  wire logic             i_rst,              // sync reset, high
	input  wire logic             i_ce,               // clock enable
	input  wire logic             i_sensor_first,     // first light sensor pin
	input  wire logic             i_sensor_second,    // second light sensor pin
	input  wire logic             i_remote_light,     // remote light input pin
	input  wire logic [CUR_W-1:0] i_phase_current_1,  // phase 1 current, pu
	input  wire logic [CUR_W-1:0] i_phase_current_2,  // phase 2 current, pu
	input  wire logic [CUR_W-1:0] i_phase_current_3,  // phase 3 current, pu
	input  wire logic [CUR_W-1:0] i_residual_first,   // residual input 1, pu
	input  wire logic [CUR_W-1:0] i_residual_second,  // residual input 2, pu
	input  wire logic [31:0]      i_date,             // calendar date
	input  wire logic [26:0]      i_time_ms,          // time of day in ms
	input  wire logic [6:0]       i_address,          // avalon byte address
	input  wire logic             i_read,             // avalon read
	input  wire logic             i_write,            // avalon write
	input  wire logic [3:0]       i_byteenable,       // avalon byte enables
	input  wire logic [31:0]      i_writedata,        // avalon write data
	output logic [31:0]           o_readdata,         // avalon read data
	output logic                  o_waitrequest,      // avalon waitrequest
	output logic [2:0]            o_stage_start,      // start per stage
	output logic [2:0]            o_stage_trip,       // trip per stage
	output logic                  o_delayed_light,    // delayed light signal
	output logic                  o_remote_light,     // remote light to matrix
	output logic                  o_force             // test forcing flag
);

	localparam int     MS_CYCLES = `CLOCK_HZ / `MS_PER_S;
	localparam int     PRE_W     = $clog2(MS_CYCLES);
	localparam int     FT_W      = $clog2(FORCE_TIMEOUT_CYCLES + 1);
	localparam int     PTR_W     = $clog2(FAULT_DEPTH);

	light_type         light_meta;
	light_type         lights;
	logic              any_light_prev;
	logic [CNT_W-1:0]  any_light_count;
	light_sel_type     stage_light_select [3];
	light_sel_type     delayed_light_select;
	logic [7:0]        delay_ms;
	logic [CUR_W-1:0]  pickup [3];
	logic [2:0]        forced_start;
	logic [2:0]        forced_trip;
	logic [FT_W-1:0]   force_timer;
	logic [CUR_W-1:0]  largest_phase_current;
	logic [1:0]        largest_phase_index;
	logic [CUR_W-1:0]  stage_current [3];
	logic [CUR_W-1:0]  load_current;
	logic [1:0]        phase_at_start;
	logic [CNT_W-1:0]  stage_start_count [3];
	logic [CNT_W-1:0]  stage_trip_count [3];
	logic [2:0]        event_done;
	logic [CUR_W-1:0]  event_peak [3];
	logic [2:0]        event_tripped;
	fault_record_type  fault_log [FAULT_DEPTH];
	logic [PTR_W-1:0]  fault_wr_ptr;
	logic [PTR_W-1:0]  fault_idx;
	fault_record_type  fault_view;
	logic              dly_light;
	logic [PRE_W-1:0]  ms_prescale;
	logic [7:0]        ms_elapsed;
	logic              accept;
	logic              wr_accept;
	logic [31:0]       rd_value;
	logic [31:0]       wr_mask;
	logic [31:0]       wr_value;
	logic              clr_light;
	logic              clr_start;
	logic              clr_trip;

	// the pins are asynchronous, only the second stage is read
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			light_meta <= '0;
			lights     <= '0;
		end
		else if (i_ce)
		begin
			light_meta <= '{i_remote_light, i_sensor_second, i_sensor_first};
			lights     <= light_meta;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			o_remote_light <= 1'b0;
		else if (i_ce)
			o_remote_light <= lights.remote_light_input;
	end

	always_comb
	begin
		largest_phase_current = i_phase_current_1;
		largest_phase_index   = 2'd1;
		if (i_phase_current_2 > largest_phase_current)
		begin
			largest_phase_current = i_phase_current_2;
			largest_phase_index   = 2'd2;
		end
		if (i_phase_current_3 > largest_phase_current)
		begin
			largest_phase_current = i_phase_current_3;
			largest_phase_index   = 2'd3;
		end
	end

	assign stage_current[0] = largest_phase_current;
	assign stage_current[1] = i_residual_first;
	assign stage_current[2] = i_residual_second;

	// avalon: one wait cycle, then a single acknowledge cycle
	assign accept    = i_ce & (i_read | i_write) & ~o_waitrequest;
	assign wr_accept = accept & i_write;
	assign wr_mask   = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}}, {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
	assign wr_value  = (rd_value & ~wr_mask) | (i_writedata & wr_mask);
	assign clr_light = wr_accept && i_address == `REG_CTRL && wr_value[`CTRL_CLR_LIGHT];
	assign clr_start = wr_accept && i_address == `REG_CTRL && wr_value[`CTRL_CLR_START];
	assign clr_trip  = wr_accept && i_address == `REG_CTRL && wr_value[`CTRL_CLR_TRIP];

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			o_waitrequest <= 1'b1;
			o_readdata    <= '0;
		end
		else if (i_ce)
		begin
			if ((i_read || i_write) && o_waitrequest)
			begin
				o_waitrequest <= 1'b0;
				o_readdata    <= i_read ? rd_value : 32'h0000_0000;
			end
			else
				o_waitrequest <= 1'b1;
		end
	end

	assign fault_view = fault_log[fault_wr_ptr - PTR_W'(1) - fault_idx];

	always_comb
	begin
		rd_value = 32'h0000_0000;
		case (i_address)
			`REG_CTRL:
				rd_value[`CTRL_FORCE] = o_force;
			`REG_STATUS:
			begin
				rd_value[`ST_LIGHT_LSB +: 3] = lights;
				rd_value[`ST_START_LSB +: 3] = o_stage_start;
				rd_value[`ST_TRIP_LSB +: 3]  = o_stage_trip;
				rd_value[`ST_FORCE]          = o_force;
				rd_value[`ST_DELAYED]        = o_delayed_light;
				rd_value[`ST_REMOTE]         = o_remote_light;
			end
			`REG_SELECT:
			begin
				rd_value[0 +: 3]               = stage_light_select[0];
				rd_value[`SEL_STRIDE +: 3]     = stage_light_select[1];
				rd_value[2 * `SEL_STRIDE +: 3] = stage_light_select[2];
				rd_value[`SEL_DLY_LSB +: 3]    = delayed_light_select;
			end
			`REG_DELAY:       rd_value[7:0]        = delay_ms;
			`REG_PICKUP0:     rd_value[CUR_W-1:0]  = pickup[0];
			`REG_PICKUP1:     rd_value[CUR_W-1:0]  = pickup[1];
			`REG_PICKUP2:     rd_value[CUR_W-1:0]  = pickup[2];
			`REG_FORCED:
			begin
				rd_value[2:0]                = forced_start;
				rd_value[`FRC_TRIP_LSB +: 3] = forced_trip;
			end
			`REG_LIGHT_CNT:   rd_value[CNT_W-1:0]  = any_light_count;
			`REG_START_CNT0:  rd_value[CNT_W-1:0]  = stage_start_count[0];
			`REG_START_CNT1:  rd_value[CNT_W-1:0]  = stage_start_count[1];
			`REG_START_CNT2:  rd_value[CNT_W-1:0]  = stage_start_count[2];
			`REG_TRIP_CNT0:   rd_value[CNT_W-1:0]  = stage_trip_count[0];
			`REG_TRIP_CNT1:   rd_value[CNT_W-1:0]  = stage_trip_count[1];
			`REG_TRIP_CNT2:   rd_value[CNT_W-1:0]  = stage_trip_count[2];
			`REG_FAULT_IDX:   rd_value[PTR_W-1:0]  = fault_idx;
			`REG_FAULT_DATE:  rd_value             = fault_view.date;
			`REG_FAULT_TIME:  rd_value[26:0]       = fault_view.time_ms;
			`REG_FAULT_INFO:
			begin
				rd_value[1:0]                 = fault_view.stage;
				rd_value[`FI_TYPE_LSB +: 2]   = fault_view.fault_type;
				rd_value[`FI_ELAPSED_DELAY_PCT_LSB +: 7]   = fault_view.elapsed_delay_pct;
				rd_value[`FI_VALID]           = fault_view.valid;
			end
			`REG_FAULT_VALUE:
			begin
				rd_value[CUR_W-1:0]             = fault_view.value;
				rd_value[`FV_LOAD_LSB +: CUR_W] = fault_view.load;
			end
			default:          rd_value = 32'h0000_0000;
		endcase
	end

	// settings; pickups as per-unit 8.8
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			stage_light_select   <= '{SEL_NONE, SEL_NONE, SEL_NONE};
			delayed_light_select <= SEL_NONE;
			pickup               <= '{`PICKUP_RESET, `PICKUP_RESET, `PICKUP_RESET};
			fault_idx            <= '0;
		end
		else if (wr_accept)
		begin
			case (i_address)
				`REG_SELECT:
				begin
					stage_light_select[0] <= light_sel_type'(wr_value[0 +: 3]);
					stage_light_select[1] <= light_sel_type'(wr_value[`SEL_STRIDE +: 3]);
					stage_light_select[2] <= light_sel_type'(wr_value[2 * `SEL_STRIDE +: 3]);
					delayed_light_select  <= light_sel_type'(wr_value[`SEL_DLY_LSB +: 3]);
				end
				`REG_PICKUP0:   pickup[0] <= wr_value[CUR_W-1:0];
				`REG_PICKUP1:   pickup[1] <= wr_value[CUR_W-1:0];
				`REG_PICKUP2:   pickup[2] <= wr_value[CUR_W-1:0];
				`REG_FAULT_IDX: fault_idx <= wr_value[PTR_W-1:0];
				default:        fault_idx <= fault_idx;
			endcase
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			delay_ms <= `DLY_RESET_MS;
		else if (wr_accept && i_address == `REG_DELAY)
		begin
			if (wr_value[7:0] < `DLY_MIN_MS)
				delay_ms <= `DLY_MIN_MS;
			else if (wr_value[7:0] > `DLY_MAX_MS)
				delay_ms <= `DLY_MAX_MS;
			else
				delay_ms <= wr_value[7:0];
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			o_force     <= 1'b0;
			force_timer <= '0;
		end
		else if (i_ce)
		begin
			if (wr_accept && i_address == `REG_CTRL)
			begin
				o_force     <= wr_value[`CTRL_FORCE];
				force_timer <= '0;
			end
			else if (o_force)
			begin
				if (force_timer == FT_W'(FORCE_TIMEOUT_CYCLES - 1))
					o_force <= 1'b0;
				force_timer <= force_timer + FT_W'(1);
			end
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			forced_start <= '0;
			forced_trip  <= '0;
		end
		else if (wr_accept && i_address == `REG_FORCED && o_force)
		begin
			forced_start <= wr_value[2:0];
			forced_trip  <= wr_value[`FRC_TRIP_LSB +: 3];
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			any_light_prev  <= 1'b0;
			any_light_count <= '0;
		end
		else if (i_ce)
		begin
			any_light_prev <= |lights;
			if ((|lights) && !any_light_prev)
				any_light_count <= clr_light ? CNT_W'(1) : any_light_count + CNT_W'(1);
			else if (clr_light)
				any_light_count <= '0;
		end
	end

	assign dly_light = select_light(delayed_light_select, lights);

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			ms_prescale     <= '0;
			ms_elapsed      <= '0;
			o_delayed_light <= 1'b0;
		end
		else if (i_ce)
		begin
			if (!dly_light)
			begin
				ms_prescale     <= '0;
				ms_elapsed      <= '0;
				o_delayed_light <= 1'b0;
			end
			else
			begin
				if (ms_prescale == PRE_W'(MS_CYCLES - 1))
				begin
					ms_prescale <= '0;
					if (ms_elapsed != `DLY_MAX_MS)
						ms_elapsed <= ms_elapsed + 8'd1;
				end
				else
					ms_prescale <= ms_prescale + PRE_W'(1);
				o_delayed_light <= ms_elapsed >= delay_ms;
			end
		end
	end

	generate
		for (genvar s = 0; s < 3; s++)
		begin : g_stage
			arc_stage #(
				.CNT_W (CNT_W)
			) u_stage (
				.i_clock         (i_clock),
				.i_rst           (i_rst),
				.i_ce            (i_ce),
				.i_sel           (stage_light_select[s]),
				.i_lights        (lights),
				.i_current       (stage_current[s]),
				.i_pickup        (pickup[s]),
				.i_force         (o_force),
				.i_forced_start  (forced_start[s]),
				.i_forced_trip   (forced_trip[s]),
				.i_clear_start   (clr_start),
				.i_clear_trip    (clr_trip),
				.o_start         (o_stage_start[s]),
				.o_trip          (o_stage_trip[s]),
				.o_start_count   (stage_start_count[s]),
				.o_trip_count    (stage_trip_count[s]),
				.o_event_done    (event_done[s]),
				.o_event_peak    (event_peak[s]),
				.o_event_tripped (event_tripped[s])
			);
		end
	endgenerate

	// load frozen while the phase stage is started
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			load_current   <= '0;
			phase_at_start <= '0;
		end
		else if (i_ce && !o_stage_start[0])
		begin
			load_current   <= largest_phase_current;
			phase_at_start <= largest_phase_index;
		end
	end

	// one record per cycle; simultaneous ends keep the lowest stage only
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			fault_wr_ptr <= '0;
			for (int r = 0; r < FAULT_DEPTH; r++)
				fault_log[r] <= '0;
		end
		else if (i_ce && (|event_done))
		begin
			fault_wr_ptr                    <= fault_wr_ptr + PTR_W'(1);
			fault_log[fault_wr_ptr].valid   <= 1'b1;
			fault_log[fault_wr_ptr].date    <= i_date;
			fault_log[fault_wr_ptr].time_ms <= i_time_ms;
			if (event_done[0])
			begin
				fault_log[fault_wr_ptr].stage      <= 2'd0;
				fault_log[fault_wr_ptr].fault_type <= phase_at_start;
				fault_log[fault_wr_ptr].value      <= event_peak[0];
				fault_log[fault_wr_ptr].load       <= load_current;
				fault_log[fault_wr_ptr].elapsed_delay_pct <= event_tripped[0] ? `ELAPSED_DELAY_PCT_TRIP : `ELAPSED_DELAY_PCT_NO_TRIP;
			end
			else
			begin
				fault_log[fault_wr_ptr].stage      <= event_done[1] ? 2'd1 : 2'd2;
				fault_log[fault_wr_ptr].fault_type <= 2'd0;
				fault_log[fault_wr_ptr].value      <= event_done[1] ? event_peak[1] : event_peak[2];
				fault_log[fault_wr_ptr].load       <= '0;
				fault_log[fault_wr_ptr].elapsed_delay_pct <=
					(event_done[1] ? event_tripped[1] : event_tripped[2]) ? `ELAPSED_DELAY_PCT_TRIP : `ELAPSED_DELAY_PCT_NO_TRIP;
			end
		end
	end

endmodule

// ==== core/arc_params.svh ====
`ifndef ARC_PARAMS_SVH
`define ARC_PARAMS_SVH

`define CLOCK_HZ        50000000
`define MS_PER_S        1000
`define FORCE_TIMEOUT_S 300
`define DLY_MIN_MS      8'd10
`define DLY_MAX_MS      8'd150
`define DLY_RESET_MS    8'd10
`define PICKUP_RESET    16'h0100
`define ELAPSED_DELAY_PCT_TRIP       7'd100
`define ELAPSED_DELAY_PCT_NO_TRIP    7'd0

`define REG_CTRL        7'h00
`define REG_STATUS      7'h04
`define REG_SELECT      7'h08
`define REG_DELAY       7'h0c
`define REG_PICKUP0     7'h10
`define REG_PICKUP1     7'h14
`define REG_PICKUP2     7'h18
`define REG_FORCED      7'h1c
`define REG_LIGHT_CNT   7'h20
`define REG_START_CNT0  7'h24
`define REG_START_CNT1  7'h28
`define REG_START_CNT2  7'h2c
`define REG_TRIP_CNT0   7'h30
`define REG_TRIP_CNT1   7'h34
`define REG_TRIP_CNT2   7'h38
`define REG_FAULT_IDX   7'h3c
`define REG_FAULT_DATE  7'h40
`define REG_FAULT_TIME  7'h44
`define REG_FAULT_INFO  7'h48
`define REG_FAULT_VALUE 7'h4c

`define CTRL_FORCE      0
`define CTRL_CLR_LIGHT  1
`define CTRL_CLR_START  2
`define CTRL_CLR_TRIP   3
`define SEL_STRIDE      4
`define SEL_DLY_LSB     12
`define ST_LIGHT_LSB    0
`define ST_START_LSB    3
`define ST_TRIP_LSB     6
`define ST_FORCE        9
`define ST_DELAYED      10
`define ST_REMOTE       11
`define FRC_TRIP_LSB    4
`define FI_TYPE_LSB     2
`define FI_ELAPSED_DELAY_PCT_LSB     8
`define FI_VALID        16
`define FV_LOAD_LSB     16

`endif

// ==== core/arc_pkg.sv ====
package arc_pkg;

	localparam int CUR_W = 16;

	typedef enum logic [2:0]
	{
		SEL_NONE          = 3'b000,
		SEL_FIRST         = 3'b001,
		SEL_SECOND        = 3'b010,
		SEL_EITHER        = 3'b011,
		SEL_REMOTE        = 3'b100,
		SEL_FIRST_REMOTE  = 3'b101,
		SEL_SECOND_REMOTE = 3'b110,
		SEL_ANY           = 3'b111
	} light_sel_type;

	typedef enum logic [0:0]
	{
		EV_IDLE   = 1'b0,
		EV_ACTIVE = 1'b1
	} event_state_type;

	typedef struct packed
	{
		logic remote_light_input;
		logic light_sensor_second;
		logic light_sensor_first;
	} light_type;

	typedef struct packed
	{
		logic             valid;
		logic [31:0]      date;
		logic [26:0]      time_ms;
		logic [1:0]       stage;
		logic [1:0]       fault_type;
		logic [CUR_W-1:0] value;
		logic [CUR_W-1:0] load;
		logic [6:0]       elapsed_delay_pct;
	} fault_record_type;

	function automatic logic select_light(input light_sel_type sel, input light_type lights);
		logic result;
		result = 1'b0;
		case (sel)
			SEL_NONE:          result = 1'b0;
			SEL_FIRST:         result = lights.light_sensor_first;
			SEL_SECOND:        result = lights.light_sensor_second;
			SEL_EITHER:        result = lights.light_sensor_first | lights.light_sensor_second;
			SEL_REMOTE:        result = lights.remote_light_input;
			SEL_FIRST_REMOTE:  result = lights.light_sensor_first | lights.remote_light_input;
			SEL_SECOND_REMOTE: result = lights.light_sensor_second | lights.remote_light_input;
			SEL_ANY:           result = |lights;
			default:           result = 1'b0;
		endcase
		return result;
	endfunction

endpackage

// ==== core/arc_stage.sv ====
`timescale 1ns/10ps
module arc_stage
	import arc_pkg::*;
#(
	parameter int CNT_W = 16
)
(
	input  wire logic             i_clock,         // system clock
	input  wire logic             i_rst,           // sync reset, high
	input  wire logic             i_ce,            // clock enable
	input  wire light_sel_type    i_sel,           // stage light source
	input  wire light_type        i_lights,        // synchronised light inputs
	input  wire logic [CUR_W-1:0] i_current,       // supervised current, pu
	input  wire logic [CUR_W-1:0] i_pickup,        // pickup, pu
	input  wire logic             i_force,         // test forcing on
	input  wire logic             i_forced_start,  // forced start value
	input  wire logic             i_forced_trip,   // forced trip value
	input  wire logic             i_clear_start,   // clear start counter
	input  wire logic             i_clear_trip,    // clear trip counter
	output logic                  o_start,         // start status
	output logic                  o_trip,          // trip status
	output logic [CNT_W-1:0]      o_start_count,   // cumulative starts
	output logic [CNT_W-1:0]      o_trip_count,    // cumulative trips
	output logic                  o_event_done,    // fault event ended
	output logic [CUR_W-1:0]      o_event_peak,    // peak current of event
	output logic                  o_event_tripped  // event reached trip
);

	logic            stage_light;
	logic            over_current;
	logic            next_start;
	logic            next_trip;
	event_state_type ev_state;

	assign stage_light = select_light(i_sel, i_lights);
	assign over_current = i_current > i_pickup;

	always_comb
	begin
		if (i_force)
		begin
			next_start = i_forced_start;
			next_trip  = i_forced_trip;
		end
		else
		begin
			next_start = stage_light;
			next_trip  = stage_light & over_current;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			o_start <= 1'b0;
			o_trip  <= 1'b0;
		end
		else if (i_ce)
		begin
			o_start <= next_start;
			o_trip  <= next_trip;
		end
	end

	// a clear in the same cycle as a new start loads the count with 1, so no start is lost
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			o_start_count <= '0;
		else if (i_ce)
		begin
			if (next_start && !o_start)
				o_start_count <= i_clear_start ? CNT_W'(1) : o_start_count + CNT_W'(1);
			else if (i_clear_start)
				o_start_count <= '0;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			o_trip_count <= '0;
		else if (i_ce)
		begin
			if (next_trip && !o_trip)
				o_trip_count <= i_clear_trip ? CNT_W'(1) : o_trip_count + CNT_W'(1);
			else if (i_clear_trip)
				o_trip_count <= '0;
		end
	end

	// one fault event spans a start period; peak and trip are gathered
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			ev_state        <= EV_IDLE;
			o_event_done    <= 1'b0;
			o_event_peak    <= '0;
			o_event_tripped <= 1'b0;
		end
		else if (i_ce)
		begin
			o_event_done <= 1'b0;
			case (ev_state)
				EV_IDLE:
					if (o_start)
					begin
						ev_state        <= EV_ACTIVE;
						o_event_peak    <= i_current;
						o_event_tripped <= o_trip;
					end
				EV_ACTIVE:
				begin
					if (i_current > o_event_peak)
						o_event_peak <= i_current;
					if (o_trip)
						o_event_tripped <= 1'b1;
					if (!o_start)
					begin
						ev_state     <= EV_IDLE;
						o_event_done <= 1'b1;
					end
				end
				default:
					ev_state <= EV_IDLE;
			endcase
		end
	end

endmodule

// ==== verif/arc_field.sv ====
`timescale 1ns/10ps
module arc_field
	import arc_pkg::*;
(
	input	wire logic		i_clock,	// clock
	input	wire light_type	i_want,		// wanted light
	output	light_type		o_pins		// pin levels
);
	always_ff @(posedge i_clock)
		o_pins <= i_want;
endmodule

// ==== verif/arc_flash_detection_checker.sv ====
`timescale 1ns/10ps
module arc_flash_detection_checker
	import arc_pkg::*;
#(
	parameter longint FORCE_TIMEOUT_CYCLES = 1000
)
(
	input	wire logic			i_clock,	// clk
	input	wire logic			i_rst,	// rst
	input	wire logic			i_ce,	// en
	input	wire logic			i_sensor_first,	// pin
	input	wire logic			i_sensor_second,	// pin
	input	wire logic			i_remote_light,	// pin
	input	wire logic [6:0]	i_address,	// bus
	input	wire logic			i_read,	// bus
	input	wire logic			i_write,	// bus
	input	wire logic [3:0]	i_byteenable,	// bus
	input	wire logic [31:0]	i_writedata,	// bus
	input	wire logic [31:0]	o_readdata,	// bus
	input	wire logic			o_waitrequest,	// bus
	input	wire logic [2:0]	o_stage_start,	// starts
	input	wire logic [2:0]	o_stage_trip,	// trips
	input	wire logic			o_delayed_light,	// delayed
	input	wire logic			o_remote_light,	// remote
	input	wire logic			o_force	// force
);
	logic	[2:0]	since;
	longint			held;
	wire	dark = !i_sensor_first && !i_sensor_second && !i_remote_light;
	wire	ctrl_wr = i_write && !o_waitrequest && i_address == 7'h00 && i_byteenable[0];
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// sync pipe still holds reset values
	always_ff @(posedge i_clock)
		if (i_rst)
			since <= 3'h0;
		else if (since != 3'h7)
			since <= since + 3'h1;
	always_ff @(posedge i_clock)
		if (i_rst || !o_force || ctrl_wr)
			held <= 0;
		else
			held <= held + 1;
	AST_BUS_ANSWER: assert property ((i_read || i_write) && o_waitrequest && i_ce |=> !o_waitrequest)
		else $error("no answer after one wait state");
	AST_UNMAPPED: assert property (i_read && !o_waitrequest && i_address >= 7'h50 |-> o_readdata == 32'h0)
		else $error("unmapped read not zero");
	AST_FORCE_WRITE: assert property (ctrl_wr |=> o_force == $past(i_writedata[0]))
		else $error("force flag not written");
	AST_FORCE_TIMEOUT: assert property (held <= FORCE_TIMEOUT_CYCLES + 2)
		else $error("force flag outlived timeout");
	AST_TRIP_START: assert property (!o_force && !$past(o_force) |-> (o_stage_trip & ~o_stage_start) == 3'h0)
		else $error("trip without start");
	AST_DARK: assert property (since == 3'h7 && !o_force && !$past(o_force) && $past(dark, 2) && $past(dark, 3)
		&& $past(dark, 4) |-> o_stage_start == 3'h0)
		else $error("start without light");
	AST_REMOTE: assert property (since == 3'h7 |-> o_remote_light == $past(i_remote_light, 3))
		else $error("remote light not passed on");
	AST_DELAYED: assert property ($rose(o_delayed_light) |-> !$past(dark, 3))
		else $error("delayed light without light");
	cover property (o_stage_trip[0] && !o_force);
	cover property (o_force && o_stage_start == 3'h5);
	cover property (i_read && !o_waitrequest);
endmodule
bind arc_flash_detection arc_flash_detection_checker #(.FORCE_TIMEOUT_CYCLES(FORCE_TIMEOUT_CYCLES)) chk_i (.*);

// ==== verif/test_arc_flash_detection.sv ====
`timescale 1ns/10ps
module test_arc_flash_detection import arc_pkg::*;;
	logic			i_clock = 0;
	logic			i_rst = 1;
	logic			rd = 0;
	logic			wr = 0;
	logic [6:0]		addr = 0;
	logic [31:0]	wdata = 0;
	logic [31:0]	date = 0;
	logic [31:0]	rdata;
	logic [31:0]	rd_o;
	logic [15:0]	ph [3] = '{16'h0, 16'h0, 16'h0};
	logic [15:0]	r1 = 0;
	logic [15:0]	r2 = 0;
	light_type		want = '0;
	light_type		pins;
	logic [2:0]		st, tr;
	logic			dl, rl, frc, wq;
	int				err_count = 0;
	int				num_checks = 0;
	always #10 i_clock = ~i_clock;
	arc_field field (.i_clock(i_clock), .i_want(want), .o_pins(pins));
	arc_flash_detection #(.FORCE_TIMEOUT_CYCLES(1000)) uut
	(
		.i_clock(i_clock), .i_rst(i_rst), .i_ce(1'b1), .i_sensor_first(pins.light_sensor_first),
		.i_sensor_second(pins.light_sensor_second), .i_remote_light(pins.remote_light_input),
		.i_phase_current_1(ph[0]), .i_phase_current_2(ph[1]), .i_phase_current_3(ph[2]),
		.i_residual_first(r1), .i_residual_second(r2), .i_date(date), .i_time_ms(date[26:0]),
		.i_address(addr), .i_read(rd), .i_write(wr), .i_byteenable(4'hf), .i_writedata(wdata),
		.o_readdata(rd_o), .o_waitrequest(wq), .o_stage_start(st), .o_stage_trip(tr),
		.o_delayed_light(dl), .o_remote_light(rl), .o_force(frc)
	);
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clock);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		do
		begin
			@(posedge i_clock);
			n++;
		end
		while (wq !== 1'b0 && n < 20);
		rdata = rd_o;
		rd <= 0;
		wr <= 0;
		if (wq !== 1'b0)
		begin
			err_count++;
			complete_run();
		end
	endtask
	function automatic logic lit(input int s, input light_type l);
		return (s[0] & l.light_sensor_first) | (s[1] & l.light_sensor_second) | (s[2] & l.remote_light_input);
	endfunction
	function automatic logic [15:0] cur();
		return 16'h00ff + 16'($urandom_range(2));
	endfunction
	initial
	begin
		int s, n, mx, scnt;
		int tcnt [3];
		int lcnt;
		logic [2:0] es, et;
		scnt = 0;
		lcnt = 0;
		tcnt = '{0, 0, 0};
		void'($urandom(32'h9db0));
		repeat (3) @(posedge i_clock);
		i_rst <= 0;
		bus(0, 7'h10, 0);
		chk(32'h100, rdata);
		bus(0, 7'h0c, 0);
		chk(32'ha, rdata);
		bus(1, 7'h0c, 32'hc8);
		bus(0, 7'h0c, 0);
		chk(32'h96, rdata);
		bus(0, 7'h50, 0);
		chk(0, rdata);
		for (s = 0; s < 8; s++)
		begin
			bus(1, 7'h08, {17'h0, s[2:0], 1'b0, s[2:0], 1'b0, s[2:0], 1'b0, s[2:0]});
			repeat (4)
			begin
				want <= light_type'(3'($urandom));
				ph <= '{cur(), cur(), cur()};
				r1 <= cur();
				r2 <= cur();
				repeat (5) @(posedge i_clock);
				mx = ph[0] > ph[1] ? ph[0] : ph[1];
				mx = ph[2] > mx ? ph[2] : mx;
				es = {3{lit(s, want)}};
				et = es & {r2 > 16'h100, r1 > 16'h100, mx > 16'h100};
				chk(es, st);
				chk(et, tr);
				chk(0, dl);
				chk(want.remote_light_input, rl);
				scnt += es[0];
				lcnt += (want != 3'h0);
				for (n = 0; n < 3; n++)
					tcnt[n] += et[n];
				want <= '0;
				repeat (5) @(posedge i_clock);
			end
		end
		bus(0, 7'h20, 0);
		chk(lcnt, rdata);
		for (n = 0; n < 3; n++)
		begin
			bus(0, 7'(7'h24 + 4 * n), 0);
			chk(scnt, rdata);
			bus(0, 7'(7'h30 + 4 * n), 0);
			chk(tcnt[n], rdata);
		end
		bus(1, 7'h00, 32'he);
		bus(0, 7'h20, 0);
		chk(0, rdata);
		bus(0, 7'h2c, 0);
		chk(0, rdata);
		bus(0, 7'h38, 0);
		chk(0, rdata);
		ph <= '{16'h100, 16'h300, 16'h200};
		date <= $urandom;
		repeat (5) @(posedge i_clock);
		want <= 3'b001;
		repeat (5) @(posedge i_clock);
		want <= '0;
		repeat (5) @(posedge i_clock);
		bus(1, 7'h3c, 0);
		bus(0, 7'h48, 0);
		chk(32'h16408, rdata);
		bus(0, 7'h4c, 0);
		chk(32'h03000300, rdata);
		bus(0, 7'h40, 0);
		chk(date, rdata);
		bus(0, 7'h44, 0);
		chk({5'h0, date[26:0]}, rdata);
		bus(1, 7'h00, 1);
		bus(1, 7'h1c, 32'h75);
		repeat (2) @(posedge i_clock);
		chk(7'h5f, {st, tr, frc});
		for (n = 0; n < 1100 && frc !== 1'b0; n++)
			@(posedge i_clock);
		chk(2'b01, {frc, n >= 995 && n <= 997});
		bus(1, 7'h1c, 32'h75);
		repeat (2) @(posedge i_clock);
		chk(6'h0, {st, tr});
		complete_run();
	end
endmodule
